// >>> hdl/doc_defines.svh
// Register map, field positions, reset values and timing figures of the stage supervisor.
`ifndef DOC_DEFINES_SVH
`define DOC_DEFINES_SVH
`define DOC_STAGES 4
`define DOC_LOG_DEPTH 12
`define DOC_A_CTRL 8'h00
`define DOC_A_HARM 8'h04
`define DOC_A_EVMASK 8'h08
`define DOC_A_LOGSEL 8'h0C
`define DOC_A_STATUS 8'h10
`define DOC_A_ANGLE 8'h14
`define DOC_R_CFG 4'h0
`define DOC_R_INFO 4'h1
`define DOC_R_PICKUP 4'h2
`define DOC_R_DELAY 4'h3
`define DOC_R_EXPECT 4'h4
`define DOC_R_REMAIN 4'h5
`define DOC_R_RATIO 4'h6
`define DOC_R_COUNT 4'h7
`define DOC_R_LOG0 4'h8
`define DOC_R_LOG1 4'h9
`define DOC_F_INRUSH 0
`define DOC_F_INV 4
`define DOC_F_CLR 8
`define DOC_RST_PICKUP 16'h0078
`define DOC_RST_DELAY 19'h0_0014
`define DOC_RST_HARM 13'h0001
`define DOC_RST_EVMASK 14'h3F3F
`define DOC_RATIO_MAX 17'h1_E848
`define DOC_CLK_NS 40
`define DOC_MS_NS 1000000
`define DOC_TICK_US 5000
`define DOC_PRE_MS 20
`define DOC_AVG_MS 200
`define DOC_VMEM_MS 500
`define DOC_TMAX_S 1800
`define DOC_RESET_PCT 97
`endif

// >>> hdl/doc_pkg.sv
// Types shared by the stage supervisor: stage states, fault records and the state record.
`include "doc_defines.svh"
package doc_pkg;
	typedef enum logic [2:0] {DOC_IDLE = 3'b001, DOC_RUN = 3'b010, DOC_BLK = 3'b100} doc_state_t;
	typedef struct packed {
		logic [31:0] ts;
		logic [1:0] evt;
		logic [2:0] phases;
		logic [2:0] group;
		logic [15:0] pre;
		logic [15:0] cur;
		logic [15:0] avg;
		logic [18:0] rem;
		logic [16:0] angle;
	} doc_rec_t;
	typedef struct packed {
		doc_state_t st;
		logic trip;
		logic [18:0] elapsed;
		logic [18:0] expect_t;
		logic [16:0] ratio;
		logic [15:0] pickup;
		logic [18:0] delay;
		logic [7:0] cnt_start;
		logic [7:0] cnt_trip;
		logic [7:0] cnt_blk;
		logic [3:0] wptr;
		logic [11:0] pend;
		doc_rec_t [`DOC_LOG_DEPTH-1:0] log;
	} doc_stage_t;
	typedef struct packed {
		doc_stage_t [`DOC_STAGES-1:0] stg;
		logic inrush_en;
		logic [3:0] inv;
		logic [12:0] harm_lim;
		logic [13:0] evmask;
		logic [1:0] log_stage;
		logic [3:0] log_entry;
		logic ready_q;
		logic [31:0] rdata;
		logic slverr;
		logic [15:0] ms_div;
		logic [31:0] ts;
		logic [`DOC_PRE_MS*1000/`DOC_TICK_US-1:0][15:0] hist;
		logic [21:0] avg_sum;
		logic [5:0] avg_n;
		logic [15:0] avg;
		logic [6:0] vmem_n;
		logic [16:0] angle_mem;
		logic [16:0] angle;
		logic [2:0] vflags;
		logic evt_valid;
		logic [1:0] evt_stage;
		logic [3:0] evt_code;
		logic [31:0] evt_time;
	} doc_regs_t;
endpackage : doc_pkg

// >>> hdl/doc_stage_supervisor.sv
// Four-stage directional overcurrent supervisor with APB registers, events and fault log.
// Notes on behaviour
// R1: Blocking input sampled once per program cycle.
// R2: Pick-up without blocking raises start, starts timing.
// R3: Pick-up while blocked raises blocked, nothing further.
// R4: Blocking during start resets timing like pick-up drop.
// R5: Blocker asserts 5 ms before delay expires; no blocker output is provided here.
// R6: Inrush enable off by default; limit in 0.01 percent.
// R7: Harmonic ratio above limit suppresses trip only.
// R8: Fixed or inverse trip delay per stage.
// R9: Report angle of current to voltage, 0.01 degree.
// R10: Inverse expected time follows highest current continuously.
// R11: Expose remaining time, 5 ms steps, 1800 s bound.
// R12: Expose highest current over pick-up, 0.01 steps.
// R13: ON and OFF storage selectable per event type.
// R14: Every emitted event carries a time stamp.
// R15: Clearable counters for start, trip, blocked occurrences.
// R16: Four independent stages with separately tagged events.
// R17: ON/OFF events: start, trip, block, voltage states.
// R18: Twelve latest fault records, oldest overwritten.
// R19: Record written only on start, trip, blocked ON.
// R20: Record holds stamp, phases, currents, time, group, angle.
// R21: Release below 97 percent of pick-up setting.
// R22: Below 1 V use memory angle 0.5 s, then zero.
`timescale 1ns/10ps
module doc_stage_supervisor #(
	parameter int LOG_DEPTH = `DOC_LOG_DEPTH,
	parameter int MS_CYCLES = `DOC_MS_NS / `DOC_CLK_NS
) (
	// Clock, reset and freeze.
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Program cycle tick and measurements, sampled on the tick.
	input wire logic cycle_tick,
	input wire logic [3:0] block_in,
	input wire logic [15:0] imax,
	input wire logic [12:0] harm_ratio,
	input wire logic [16:0] angle_in,
	input wire logic volt_low,
	input wire logic [2:0] fault_phases,
	input wire logic [2:0] setting_group,
	// Stage outputs.
	output logic [3:0] stage_start,
	output logic [3:0] stage_trip,
	output logic [3:0] stage_blocked,
	// Event stream toward the event buffer.
	output logic evt_valid,
	output logic [1:0] evt_stage,
	output logic [3:0] evt_code,
	output logic [31:0] evt_time
);
	import doc_pkg::*;

	// Counts in program cycles, derived from the printed times.
	localparam int PRE_TICKS = `DOC_PRE_MS * 1000 / `DOC_TICK_US;
	localparam int AVG_TICKS = `DOC_AVG_MS * 1000 / `DOC_TICK_US;
	localparam int VMEM_TICKS = `DOC_VMEM_MS * 1000 / `DOC_TICK_US;
	localparam logic [18:0] TMAX = 19'(`DOC_TMAX_S * 1000 * 1000 / `DOC_TICK_US);

	// Refuse settings the fixed storage cannot serve.
	if (LOG_DEPTH != `DOC_LOG_DEPTH || MS_CYCLES < 2 || MS_CYCLES > 65535 ||
		AVG_TICKS > 64 || VMEM_TICKS > 127) begin : bad_params
		$error("doc_stage_supervisor: unsupported parameter values");
	end

	// Pick-up with hysteresis: once held, it drops only below the reset ratio.
	function automatic logic pick_next(input logic held, input logic [15:0] cur,
		input logic [15:0] set);
		logic [22:0] c100;
		logic [22:0] sr;
		c100 = 23'(cur) * 23'h64;
		sr = 23'(set) * 23'(`DOC_RESET_PCT);
		return held ? (c100 >= sr) : (cur > set);
	endfunction : pick_next

	// Current over pick-up in hundredths, saturated at the top of the range.
	function automatic logic [16:0] ratio_of(input logic [15:0] cur, input logic [15:0] set);
		logic [22:0] q;
		q = (set == 16'h0) ? 23'h7F_FFFF : (23'(cur) * 23'h64) / 23'(set);
		return (q > 23'(`DOC_RATIO_MAX)) ? `DOC_RATIO_MAX : q[16:0];
	endfunction : ratio_of

	// Simplified inverse law: delay scaled by one over the overcurrent margin.
	function automatic logic [18:0] inv_time(input logic [18:0] dly, input logic [16:0] rt);
		logic [25:0] q;
		q = (rt <= 17'h64) ? 26'(TMAX) : (26'(dly) * 26'h64) / 26'(rt - 17'h64);
		return (q > 26'(TMAX)) ? TMAX : q[18:0];
	endfunction : inv_time

	// Remaining time is zero outside a countdown and once the delay has run out.
	function automatic logic [18:0] remain_of(input doc_state_t st, input logic [18:0] ex,
		input logic [18:0] el);
		return (st == DOC_RUN && ex > el) ? ex - el : 19'h0;
	endfunction : remain_of

	// Reset image of the whole state record.
	function automatic doc_regs_t reset_value();
		doc_regs_t r;
		r = '0;
		for (int i = 0; i < `DOC_STAGES; i++) begin
			r.stg[i].st = DOC_IDLE;
			r.stg[i].pickup = `DOC_RST_PICKUP;
			r.stg[i].delay = `DOC_RST_DELAY;
		end
		r.harm_lim = `DOC_RST_HARM;
		r.evmask = `DOC_RST_EVMASK;
		return r;
	endfunction : reset_value

	localparam doc_regs_t RESET_STATE = reset_value();

	doc_regs_t s; // Registered state.
	doc_regs_t n; // Next state.
	logic ctrl_clr; // Counter clear strobe from a control write.

	assign ctrl_clr = psel && penable && pwrite && s.ready_q && paddr == `DOC_A_CTRL &&
		pwdata[`DOC_F_CLR];

	// Outputs are decoded from registered state only, except pready, which is also gated by ce.
	for (genvar g = 0; g < `DOC_STAGES; g++) begin : outs
		assign stage_start[g] = s.stg[g].st == DOC_RUN;
		assign stage_trip[g] = s.stg[g].trip;
		assign stage_blocked[g] = s.stg[g].st == DOC_BLK;
	end
	assign prdata = s.rdata;
	assign pslverr = s.slverr;
	assign pready = ce && s.ready_q;
	assign evt_valid = s.evt_valid;
	assign evt_stage = s.evt_stage;
	assign evt_code = s.evt_code;
	assign evt_time = s.evt_time;

	// All next-state logic: bus, time base, event drain and the per-tick stage update.
	always_comb begin
		logic found;
		logic hit;
		logic hb;
		logic [31:0] rd;
		logic [5:0] fo;
		logic [5:0] fn;
		logic [5:0] rise;
		logic [18:0] ex;
		logic [18:0] nel;
		logic [16:0] rt;
		doc_rec_t rec;
		found = 1'b0;
		hit = 1'b1;
		hb = 1'b0;
		rd = 32'h0;
		fo = 6'h0;
		fn = 6'h0;
		rise = 6'h0;
		ex = 19'h0;
		nel = 19'h0;
		rt = 17'h0;
		rec = '0;
		n = s;
		n.evt_valid = 1'b0;
		// Millisecond time stamp base.
		if (s.ms_div == 16'(MS_CYCLES - 1)) begin
			n.ms_div = 16'h0;
			n.ts = s.ts + 32'h1;
		end else begin
			n.ms_div = s.ms_div + 16'h1;
		end
		// Read decode; unmapped addresses answer with an error.
		case (paddr[7:4])
			`DOC_R_CFG: begin
				case (paddr[3:2])
					2'h0: rd = {24'h0, s.inv, 3'h0, s.inrush_en};
					2'h1: rd = {19'h0, s.harm_lim}; // [R6]
					2'h2: rd = {18'h0, s.evmask};
					default: rd = {24'h0, s.log_entry, 2'h0, s.log_stage};
				endcase
			end
			`DOC_R_INFO: begin
				if (paddr[3:2] == 2'h0) begin
					rd = {17'h0, s.vflags, stage_blocked, stage_trip, stage_start};
				end else if (paddr[3:2] == 2'h1) begin
					rd = {{15{s.angle[16]}}, s.angle}; // [R9]
				end else begin
					hit = 1'b0;
				end
			end
			`DOC_R_PICKUP: rd = {16'h0, s.stg[paddr[3:2]].pickup};
			`DOC_R_DELAY: rd = {13'h0, s.stg[paddr[3:2]].delay};
			`DOC_R_EXPECT: rd = {13'h0, s.stg[paddr[3:2]].expect_t}; // [R10]
			`DOC_R_REMAIN: rd = {13'h0, remain_of(s.stg[paddr[3:2]].st,
				s.stg[paddr[3:2]].expect_t, s.stg[paddr[3:2]].elapsed)}; // [R11]
			`DOC_R_RATIO: rd = {15'h0, s.stg[paddr[3:2]].ratio}; // [R12]
			`DOC_R_COUNT: rd = {8'h0, s.stg[paddr[3:2]].cnt_blk, s.stg[paddr[3:2]].cnt_trip,
				s.stg[paddr[3:2]].cnt_start}; // [R15]
			`DOC_R_LOG0, `DOC_R_LOG1: begin
				// An entry past the log depth reads as zero.
				if (s.log_entry < 4'(LOG_DEPTH)) begin
					rec = s.stg[s.log_stage].log[s.log_entry];
				end
				case ({paddr[4], paddr[3:2]})
					3'h0: rd = rec.ts;
					3'h1: rd = {4'h0, rec.evt, rec.phases, rec.group, 3'h0, rec.angle};
					3'h2: rd = {rec.pre, rec.cur};
					3'h3: rd = {13'h0, rec.rem};
					3'h4: rd = {16'h0, rec.avg};
					default: hit = 1'b0;
				endcase
			end
			default: hit = 1'b0;
		endcase
		// Ready follows one cycle after setup; data is captured before it.
		n.ready_q = psel && !(penable && s.ready_q);
		if (psel && !s.ready_q) begin
			n.rdata = rd;
			n.slverr = !hit;
		end
		// Writes take effect at the completing edge only.
		if (psel && penable && pwrite && s.ready_q) begin
			case (paddr[7:4])
				`DOC_R_CFG: begin
					case (paddr[3:2])
						2'h0: begin
							n.inrush_en = pwdata[`DOC_F_INRUSH]; // [R6]
							n.inv = pwdata[`DOC_F_INV +: 4]; // [R8]
						end
						2'h1: n.harm_lim = pwdata[12:0]; // [R6]
						2'h2: n.evmask = pwdata[13:0]; // [R13]
						default: begin
							n.log_stage = pwdata[1:0];
							n.log_entry = pwdata[7:4];
						end
					endcase
				end
				`DOC_R_PICKUP: n.stg[paddr[3:2]].pickup = pwdata[15:0];
				`DOC_R_DELAY: n.stg[paddr[3:2]].delay = pwdata[18:0];
				default: begin
				end
			endcase
		end
		// Drain one pending event per cycle, lowest stage first, stamped at emission.
		for (int i = 0; i < `DOC_STAGES; i++) begin
			for (int b = 0; b < 12; b++) begin
				if (!found && s.stg[i].pend[b]) begin
					found = 1'b1;
					n.stg[i].pend[b] = 1'b0;
					n.evt_valid = 1'b1;
					n.evt_stage = 2'(i); // [R16]
					n.evt_code = 4'(b);
					n.evt_time = s.ts; // [R14]
				end
			end
			// Clear first so that a count arriving in the same cycle survives.
			if (ctrl_clr) begin
				n.stg[i].cnt_start = 8'h0;
				n.stg[i].cnt_trip = 8'h0;
				n.stg[i].cnt_blk = 8'h0;
			end
		end
		// Program cycle work: every stage decision is made on the tick alone.
		if (cycle_tick) begin // [R1]
			// Voltage memory: hold the last healthy angle, then force zero.
			if (!volt_low) begin
				n.vmem_n = 7'h0;
				n.angle_mem = angle_in;
				n.angle = angle_in; // [R9]
				n.vflags = 3'b010;
			end else begin
				if (s.vmem_n < 7'(VMEM_TICKS)) begin
					n.vmem_n = s.vmem_n + 7'h1;
					n.angle = s.angle_mem; // [R22]
					n.vflags = 3'b100;
				end else begin
					n.angle = 17'h0; // [R22]
					n.vflags = 3'b001;
				end
			end
			// Pre-trigger history and block averages of the highest current.
			n.hist[0] = imax;
			for (int k = 1; k < PRE_TICKS; k++) begin
				n.hist[k] = s.hist[k-1];
			end
			if (s.avg_n == 6'(AVG_TICKS - 1)) begin
				n.avg = 16'((s.avg_sum + 22'(imax)) / 22'(AVG_TICKS));
				n.avg_sum = 22'h0;
				n.avg_n = 6'h0;
			end else begin
				n.avg_sum = s.avg_sum + 22'(imax);
				n.avg_n = s.avg_n + 6'h1;
			end
			hb = s.inrush_en && (harm_ratio > s.harm_lim); // [R7]
			for (int i = 0; i < `DOC_STAGES; i++) begin
				rt = ratio_of(imax, s.stg[i].pickup); // [R12]
				ex = s.inv[i] ? inv_time(s.stg[i].delay, rt) : s.stg[i].delay; // [R8] [R10]
				nel = (s.stg[i].elapsed == TMAX) ? TMAX : s.stg[i].elapsed + 19'h1; // [R11]
				n.stg[i].ratio = rt;
				n.stg[i].expect_t = ex;
				case (s.stg[i].st)
					DOC_IDLE: begin
						if (pick_next(1'b0, imax, s.stg[i].pickup)) begin
							n.stg[i].st = block_in[i] ? DOC_BLK : DOC_RUN; // [R2] [R3]
						end
						n.stg[i].elapsed = 19'h0;
						n.stg[i].trip = 1'b0;
					end
					DOC_RUN: begin
						if (!pick_next(1'b1, imax, s.stg[i].pickup) || block_in[i]) begin
							n.stg[i].st = DOC_IDLE; // [R4] [R21]
							n.stg[i].elapsed = 19'h0;
							n.stg[i].trip = 1'b0;
						end else begin
							n.stg[i].elapsed = nel;
							n.stg[i].trip = (nel >= ex) && !hb; // [R7]
						end
					end
					DOC_BLK: begin
						if (!pick_next(1'b1, imax, s.stg[i].pickup)) begin
							n.stg[i].st = DOC_IDLE; // [R3]
						end
					end
					default: begin
						n.stg[i].st = DOC_IDLE;
						n.stg[i].elapsed = 19'h0;
						n.stg[i].trip = 1'b0;
					end
				endcase
				// Transitions of the six event sources, ON on rise and OFF on fall.
				fo = {s.vflags, s.stg[i].st == DOC_BLK, s.stg[i].trip, s.stg[i].st == DOC_RUN};
				fn = {n.vflags, n.stg[i].st == DOC_BLK, n.stg[i].trip, n.stg[i].st == DOC_RUN};
				rise = fn & ~fo;
				for (int t = 0; t < 6; t++) begin
					if (rise[t] && s.evmask[t]) begin
						n.stg[i].pend[2*t+1] = 1'b1; // [R13] [R17]
					end
					if (!fn[t] && fo[t] && s.evmask[8+t]) begin
						n.stg[i].pend[2*t] = 1'b1; // [R13] [R17]
					end
				end
				if (rise[0]) begin
					n.stg[i].cnt_start = n.stg[i].cnt_start + 8'h1; // [R15]
				end
				if (rise[1]) begin
					n.stg[i].cnt_trip = n.stg[i].cnt_trip + 8'h1; // [R15]
				end
				if (rise[2]) begin
					n.stg[i].cnt_blk = n.stg[i].cnt_blk + 8'h1; // [R15]
				end
				// One record per tick; a trip outranks a start of the same tick.
				if (rise[2:0] != 3'h0) begin // [R19]
					rec.ts = s.ts;
					rec.evt = rise[1] ? 2'h1 : (rise[0] ? 2'h0 : 2'h2);
					rec.phases = fault_phases;
					rec.group = setting_group;
					rec.pre = s.hist[PRE_TICKS-1];
					rec.cur = imax;
					rec.avg = s.avg;
					rec.rem = remain_of(n.stg[i].st, ex, n.stg[i].elapsed);
					rec.angle = n.angle; // [R20]
					n.stg[i].log[s.stg[i].wptr] = rec;
					n.stg[i].wptr = (s.stg[i].wptr == 4'(LOG_DEPTH - 1)) ? 4'h0 :
						s.stg[i].wptr + 4'h1; // [R18]
				end
			end
		end
	end

	// State register; the clock enable freezes everything.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= RESET_STATE;
		end else if (ce) begin
			s <= n;
		end
	end

	// Checks on each stage.
	for (genvar g = 0; g < `DOC_STAGES; g++) begin : chk
		sequence tick_s;
			ce && cycle_tick;
		endsequence
		sequence fresh_pick_s;
			tick_s ##0 (s.stg[g].st == DOC_IDLE && imax > s.stg[g].pickup);
		endsequence
		start_on_pick_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
			fresh_pick_s ##0 !block_in[g] |=> stage_start[g] && s.stg[g].elapsed == 19'h0)
			else $error("start not raised on pick-up");
		block_on_pick_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
			fresh_pick_s ##0 block_in[g] |=> stage_blocked[g] && !stage_start[g])
			else $error("blocked not raised on blocked pick-up");
		blk_release_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
			tick_s ##0 (stage_start[g] && block_in[g]) |=>
			!stage_start[g] && !stage_trip[g] && s.stg[g].elapsed == 19'h0)
			else $error("timing not reset by blocking");
		tick_only_a: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
			!(ce && cycle_tick) |=> $stable(s.stg[g].st) && $stable(s.stg[g].trip))
			else $error("stage changed between ticks");
		inrush_trip_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
			tick_s ##0 (s.inrush_en && harm_ratio > s.harm_lim) |=> !stage_trip[g])
			else $error("trip not suppressed by inrush");
		hyst_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [R21]
			tick_s ##0 (stage_start[g] && !block_in[g] &&
			23'(imax) * 23'h64 >= 23'(s.stg[g].pickup) * 23'h61) |=> stage_start[g])
			else $error("start dropped inside hysteresis band");
		cnt_start_a: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
			$rose(stage_start[g]) && !$past(ctrl_clr) |->
			s.stg[g].cnt_start == $past(s.stg[g].cnt_start) + 8'h1)
			else $error("start counter missed an occurrence");
		log_wrap_a: assert property (@(posedge clock) disable iff (!rst_n) // [R18] [R19]
			$rose(stage_trip[g]) |-> s.stg[g].wptr == (($past(s.stg[g].wptr) ==
			4'(LOG_DEPTH - 1)) ? 4'h0 : $past(s.stg[g].wptr) + 4'h1))
			else $error("fault log pointer wrong after trip");
	end

	vmem_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // [R22]
		ce && cycle_tick && volt_low && s.vmem_n >= 7'(VMEM_TICKS) |=> s.angle == 17'h0)
		else $error("angle not forced to zero after memory time");

endmodule : doc_stage_supervisor

// >>> tb/doc_far_side.sv
// Far-side model: program cycle source, blocking matrix and event buffer of the supervisor.
`timescale 1ns/10ps
module doc_far_side #(
	parameter int TICK_CYC = 128
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Requests from the test sequence.
	input wire logic [3:0] block_req,
	input wire logic clr,
	// Event stream from the supervisor.
	input wire logic evt_valid,
	input wire logic [1:0] evt_stage,
	input wire logic [3:0] evt_code,
	input wire logic [31:0] evt_time,
	// Program cycle and blocking matrix outputs.
	output logic cycle_tick,
	output logic [3:0] block_in,
	// Event buffer view: one bit per stage and event code, and the latest stamp.
	output logic [63:0] seen,
	output logic [31:0] last_time
);
	int cnt; // Position inside the program cycle.

	// One process plays all three far-side parties; they share one clock.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			cycle_tick <= 1'b0;
			block_in <= 4'h0;
			seen <= '0;
			last_time <= 32'h0000_0000;
		end else begin
			cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
			cycle_tick <= (cnt == TICK_CYC - 1);
			// The sequence changes requests long before a tick, so blocking lands in time.
			block_in <= block_req;
			if (clr) begin
				seen <= '0;
			end else if (evt_valid) begin
				seen[{evt_stage, evt_code}] <= 1'b1;
				last_time <= evt_time;
			end
		end
	end
endmodule : doc_far_side

// >>> tb/tb_protection_stage_block_event_logger.sv
// Self-checking testbench of the stage supervisor with its far-side model.
`timescale 1ns/10ps
module tb_protection_stage_block_event_logger;
	import doc_pkg::*;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, volt_low, clr, cycle_tick;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat, evt_time, last_time, sum;
	logic rerr, evt_valid;
	logic [15:0] imax;
	logic [12:0] harm_ratio;
	logic [16:0] angle_in;
	logic [2:0] fault_phases, setting_group;
	logic [3:0] block_req, block_in, stage_start, stage_trip, stage_blocked, evt_code;
	logic [1:0] evt_stage;
	logic [63:0] seen;
	int n_mismatch, n_tests;

	// Design with a short millisecond divider so stamps move quickly.
	doc_stage_supervisor #(.LOG_DEPTH(12), .MS_CYCLES(10)) uut (.clock(clock), .rst_n(rst_n),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cycle_tick(cycle_tick), .block_in(block_in), .imax(imax), .harm_ratio(harm_ratio),
		.angle_in(angle_in), .volt_low(volt_low), .fault_phases(fault_phases),
		.setting_group(setting_group), .stage_start(stage_start), .stage_trip(stage_trip),
		.stage_blocked(stage_blocked), .evt_valid(evt_valid), .evt_stage(evt_stage),
		.evt_code(evt_code), .evt_time(evt_time));

	// Far side: tick source, blocking matrix and event buffer.
	doc_far_side #(.TICK_CYC(128)) far (.clock(clock), .rst_n(rst_n), .block_req(block_req),
		.clr(clr), .evt_valid(evt_valid), .evt_stage(evt_stage), .evt_code(evt_code),
		.evt_time(evt_time), .cycle_tick(cycle_tick), .block_in(block_in), .seen(seen),
		.last_time(last_time));

	// Free-running 25 MHz clock.
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Prints the verdict and ends the run.
	task automatic test_done;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	// Compares one result word.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; the answer is taken at the edge where pready is high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		if (n >= 20) begin
			chk(32'h0000_0000, 32'h0000_0001);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Reads a register and compares it with the expected word.
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp);
	endtask : rdc

	// Waits for n program-cycle ticks, then lets outputs and events settle.
	task automatic ticks(input int n);
		repeat (n) begin
			do @(negedge clock); while (cycle_tick !== 1'b1);
			@(negedge clock);
		end
		repeat (50) @(negedge clock);
	endtask : ticks

	// Drives the measured current at a rising edge.
	task automatic cur(input logic [15:0] v);
		@(posedge clock);
		imax <= v;
	endtask : cur

	// Cuts a hung run short.
	initial begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		test_done;
	end

	// Main sequence.
	initial begin
		n_mismatch = 0;
		n_tests = 0;
		rst_n = 1'b0;
		{psel, penable, pwrite, volt_low, clr} = 5'h00;
		{paddr, pwdata, imax, harm_ratio, angle_in} = '0;
		{fault_phases, setting_group, block_req} = 10'h0A0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		// Reset values and an unmapped word.
		rdc(8'h20, 32'h0000_0078);
		rdc(8'h30, 32'h0000_0014);
		rdc(8'h04, 32'h0000_0001);
		rdc(8'h08, 32'h0000_3F3F);
		rdc(8'h00, 32'h0000_0000);
		rdc(8'h18, 32'h0000_0000);
		chk({31'h0, rerr}, 32'h0000_0001);
		// Stage 0 only picks up; fixed delay of three ticks.
		for (int s = 1; s < 4; s++) apb(1'b1, 8'h20 + 8'(4 * s), 32'h0000_FFFF);
		apb(1'b1, 8'h20, 32'h0000_0064);
		apb(1'b1, 8'h30, 32'h0000_0003);
		cur(16'h0096);
		ticks(1);
		// Voltage stays healthy until the voltage-loss step, so the live-angle flag (bit 13) shows in every status word read before it.
		rdc(8'h10, 32'h0000_2001);
		chk({31'h0, seen[1]}, 32'h0000_0001);
		ticks(2);
		rdc(8'h10, 32'h0000_2001);
		rdc(8'h50, 32'h0000_0001);
		ticks(1);
		rdc(8'h10, 32'h0000_2011);
		chk({31'h0, seen[3]}, 32'h0000_0001);
		chk({31'h0, last_time > 0}, 32'h0000_0001);
		chk({14'h0, seen[53:48], seen[37:32], seen[21:16]}, 32'h0000_0000);
		chk({31'h0, seen[25]}, 32'h0000_0001);
		// Records: start then trip, current captured.
		apb(1'b1, 8'h0C, 32'h0000_0000);
		apb(1'b0, 8'h84, 32'h0000_0000);
		chk({30'h0, rdat[27:26]}, 32'h0000_0000);
		chk({26'h0, rdat[25:20]}, 32'h0000_000A);
		apb(1'b0, 8'h88, 32'h0000_0000);
		chk({16'h0, rdat[15:0]}, 32'h0000_0096);
		apb(1'b1, 8'h0C, 32'h0000_0010);
		apb(1'b0, 8'h84, 32'h0000_0000);
		chk({30'h0, rdat[27:26]}, 32'h0000_0001);
		// Hysteresis: 98 holds, 96 releases.
		cur(16'h0062);
		ticks(1);
		rdc(8'h10, 32'h0000_2011);
		cur(16'h0060);
		ticks(1);
		rdc(8'h10, 32'h0000_2000);
		chk({31'h0, seen[0]}, 32'h0000_0001);
		// Blocking during start resets, then a fresh pick-up is blocked.
		cur(16'h0096);
		ticks(1);
		@(posedge clock);
		block_req <= 4'h1;
		ticks(1);
		rdc(8'h10, 32'h0000_2000);
		ticks(1);
		rdc(8'h10, 32'h0000_2100);
		chk({31'h0, seen[5]}, 32'h0000_0001);
		block_req <= 4'h0;
		ticks(1);
		rdc(8'h10, 32'h0000_2100);
		cur(16'h0000);
		ticks(1);
		rdc(8'h70, 32'h0001_0102);
		apb(1'b1, 8'h00, 32'h0000_0100);
		rdc(8'h70, 32'h0000_0000);
		// A blocking pulse between ticks is never seen.
		block_req <= 4'h1;
		repeat (5) @(posedge clock);
		block_req <= 4'h0;
		cur(16'h0096);
		ticks(1);
		rdc(8'h10, 32'h0000_2001);
		// Inrush blocking holds back only the trip.
		apb(1'b1, 8'h00, 32'h0000_0001);
		apb(1'b1, 8'h04, 32'h0000_0064);
		harm_ratio <= 13'h00C8;
		ticks(4);
		rdc(8'h10, 32'h0000_2001);
		harm_ratio <= 13'h0000;
		ticks(1);
		rdc(8'h10, 32'h0000_2011);
		cur(16'h0000);
		// Inverse delay follows the current.
		apb(1'b1, 8'h00, 32'h0000_0010);
		apb(1'b1, 8'h30, 32'h0000_0014);
		cur(16'h012C);
		ticks(2);
		rdc(8'h40, 32'h0000_000A);
		rdc(8'h60, 32'h0000_012C);
		cur(16'h01F4);
		ticks(2);
		rdc(8'h40, 32'h0000_0005);
		cur(16'h0000);
		ticks(1);
		// Start ON masked out, start OFF kept.
		apb(1'b1, 8'h08, 32'h0000_3F3E);
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		cur(16'h0096);
		ticks(1);
		chk({31'h0, seen[1]}, 32'h0000_0000);
		cur(16'h0000);
		ticks(1);
		chk({31'h0, seen[0]}, 32'h0000_0001);
		// Negative angle is reported sign-extended.
		@(posedge clock);
		angle_in <= 17'h1_F000;
		ticks(1);
		rdc(8'h14, 32'hFFFF_F000);
		// Voltage loss: the held angle stands for the memory time, then zero.
		@(posedge clock);
		angle_in <= 17'h0_0000;
		volt_low <= 1'b1;
		ticks(1);
		rdc(8'h14, 32'hFFFF_F000);
		rdc(8'h10, 32'h0000_4000);
		ticks(100);
		rdc(8'h14, 32'h0000_0000);
		rdc(8'h10, 32'h0000_1000);
		volt_low <= 1'b0;
		// Twelve new starts overwrite every slot exactly once.
		for (int i = 0; i < 12; i++) begin
			cur(16'h0096 + 16'(i));
			ticks(1);
			cur(16'h0000);
			ticks(1);
		end
		sum = 32'h0000_0000;
		for (int e = 0; e < 12; e++) begin
			apb(1'b1, 8'h0C, {24'h0, 4'(e), 4'h0});
			apb(1'b0, 8'h88, 32'h0000_0000);
			sum = sum + {16'h0, rdat[15:0]};
		end
		chk(sum, 32'h0000_074A);
		apb(1'b1, 8'h0C, 32'h0000_00C0);
		rdc(8'h80, 32'h0000_0000);
		test_done;
	end
endmodule : tb_protection_stage_block_event_logger
